//--- rtl/afis_pkg.sv
// package: constants, types and field layouts of the afe input sequencer
//------------------------------------------------------------------------
// Overview of operation
// (R1) sense differential or single-ended clock automatically
// (R2) clock-select high means pixel-rate clock supplied
// (R3) multiplier three, two, or one in single-input
// (R4) triple mode emits three inputs in programmed order
// (R5) dual mode: blue even, green odd pixels
// (R6) single multicolor routes all pixels via selected input
// (R7) red coefficient set steps per line pulse
// (R8) first line pulse selects first programmed input
// (R9) each later line pulse advances to next input
// (R10) after third input wrap to first, forever
// (R11) clamp pulse: programmable delay and width pixels
// (R12) clamp switch closes while clamp control asserted
// (R13) gated clamp is clamp AND sample strobe
// (R14) black level loop manual or automatic per channel
// (R15) automatic loop updates offset from black pixels
// (R16) per-input sample-hold or correlated double sampling
// (R17) input buffer enable bit drives all three buffers
// (R18) dual mode alternates even and odd per cycle
//------------------------------------------------------------------------
package afis_pkg;

   localparam int  SAMPLE_W      = 16;
   localparam int  OFFSET_W      = 10;
   localparam int  PIXCNT_W      = 12;
   localparam int  FIFO_DEPTH    = 8;
   localparam int  NUM_SETS_MAX  = 5;
   // clock and format-sense window
   localparam int  CLK_MHZ       = 100;
   localparam int  SENSE_NS      = 200;
   localparam int  SENSE_CYC     = (SENSE_NS * CLK_MHZ) / 1000;
   localparam int  SENSE_W       = 8;
   // clock-select and input-buffer enable bit positions in the first main configuration word
   localparam int  CLKSEL_BIT    = 2;
   localparam int  INBUF_BIT     = 7;
   // multipliers
   localparam logic [1:0] MULT_ONE   = 2'h1;
   localparam logic [1:0] MULT_TWO   = 2'h2;
   localparam logic [1:0] MULT_THREE = 2'h3;
   // channel codes
   localparam logic [1:0] CH_RED   = 2'h0;
   localparam logic [1:0] CH_GREEN = 2'h1;
   localparam logic [1:0] CH_BLUE  = 2'h2;
   // reset values and black-level target
   localparam logic [OFFSET_W-1:0] OFFSET_RST = 10'h200;
   localparam logic [SAMPLE_W-1:0] BLACK_TGT  = 16'h0100;
   localparam logic [2:0]          SET_ZERO   = 3'h0;

   typedef enum logic [1:0] {
      MODE_TRIPLE,
      MODE_DUAL,
      MODE_SINGLE_MULTI,
      MODE_LINE_SEQ
   } afis_mode_t;

   // word handed to the converter path
   typedef struct packed {
      logic [1:0]          chan;
      logic [2:0]          coefSet;
      logic [SAMPLE_W-1:0] data;
   } afis_conv_t;

   localparam int CONV_W = $bits(afis_conv_t);

   // three samples taken together at pixel rate
   typedef struct packed {
      logic [SAMPLE_W-1:0] red;
      logic [SAMPLE_W-1:0] green;
      logic [SAMPLE_W-1:0] blue;
   } afis_pixel_t;

endpackage : afis_pkg

//--- rtl/afis_input_sequencer.sv
// afe input sequencer: clock setup, input steering, clamp and fifo
`timescale 1ns/100ps

//------------------------------------------------------------------------
// fifo between the steering logic and the converter
//------------------------------------------------------------------------
module afis_fifo
   import afis_pkg::*;
#(
   parameter int WIDTH = CONV_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // fill side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // drain side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_r;
   logic [AW-1:0]    rdPtr_r;
   logic [AW:0]      count_r;
   logic             push;
   logic             pop;

   // honest flags straight from the occupancy count
   assign inReady  = (count_r != (AW+1)'(DEPTH));
   assign outValid = (count_r != '0);
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;
   assign outData  = mem[rdPtr_r];

   // storage has no reset; only pointers and count need a defined state
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_r] <= inData;
      end
   end

   // pointers wrap at depth, which need not be a power of two
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
         end
         if (pop) begin
            rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : afis_fifo

//------------------------------------------------------------------------
// top: input sequencer
//------------------------------------------------------------------------
module afis_input_sequencer
   import afis_pkg::*;
(
   // clock and reset
   input  wire logic                clk,
   input  wire logic                sys_rst,
   // sampled levels of the two clock input pins
   input  wire logic                clkPosLevel,
   input  wire logic                clkNegLevel,
   // configuration
   input  wire logic [7:0]          mainConfig1,
   input  wire afis_mode_t          mode,
   input  wire logic [5:0]          chanOrder,
   input  wire logic [1:0]          singleSel,
   input  wire logic [2:0]          numColorSets,
   input  wire logic [PIXCNT_W-1:0] clampDelay,
   input  wire logic [PIXCNT_W-1:0] clampWidth,
   input  wire logic                clampGateEn,
   input  wire logic [2:0]          blcAuto,
   input  wire logic [3*OFFSET_W-1:0] manualOffset,
   input  wire logic [2:0]          cdsSel,
   // sensor timing
   input  wire logic                lineTransferPulse,
   input  wire logic                sampleStrobe,
   // pixel stream in
   input  wire logic                pixValid,
   output logic                     pixReady,
   input  wire afis_pixel_t         pixData,
   // converter stream out
   output logic                     convValid,
   input  wire logic                convReady,
   output afis_conv_t               convWord,
   // status and analog controls
   output logic                     clkDiff_r,
   output logic [1:0]               mult_r,
   output logic                     inputClamp_r,
   output logic                     clampSwitch,
   output logic [2:0]               inBufEn_r,
   output logic [2:0]               cdsMode_r,
   output logic [3*OFFSET_W-1:0]    offset_r,
   output logic [1:0]               activeChan_r,
   output logic [2:0]               coefSet_r
);

   //---------------------------------------------------------------------
   // clock format sense
   //---------------------------------------------------------------------
   logic               negPrev_r;
   logic [SENSE_W-1:0] quietCnt_r;

   // a grounded complementary pin never toggles; one toggle proves a pair
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         negPrev_r  <= 1'b0;
         quietCnt_r <= '0;
         clkDiff_r  <= 1'b0;
      end else begin
         negPrev_r <= clkNegLevel;
         if (clkNegLevel != negPrev_r) begin
            quietCnt_r <= '0;
            clkDiff_r  <= 1'b1;                          // [R1]
         end else if (quietCnt_r == SENSE_W'(SENSE_CYC)) begin
            clkDiff_r  <= 1'b0;                          // [R1]
         end else begin
            quietCnt_r <= quietCnt_r + 1'b1;
         end
      end
   end

   //---------------------------------------------------------------------
   // clock multiplier and static controls
   //---------------------------------------------------------------------
   logic pixClkSel;

   assign pixClkSel = mainConfig1[CLKSEL_BIT];           // [R2]

   // single-input modes ignore the select: pixel and converter rates match
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mult_r <= MULT_ONE;
      end else if (!pixClkSel) begin
         mult_r <= MULT_ONE;                             // [R2]
      end else begin
         case (mode)
            MODE_TRIPLE: mult_r <= MULT_THREE;           // [R3]
            MODE_DUAL:   mult_r <= MULT_TWO;             // [R3]
            default:     mult_r <= MULT_ONE;             // [R3]
         endcase
      end
   end

   // buffer enable and front-end style are plain register copies
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         inBufEn_r <= '0;
         cdsMode_r <= '0;
      end else begin
         inBufEn_r <= {3{mainConfig1[INBUF_BIT]}};       // [R17]
         cdsMode_r <= cdsSel;                            // [R16]
      end
   end

   //---------------------------------------------------------------------
   // line sequencing
   //---------------------------------------------------------------------
   afis_mode_t modePrev_r;
   logic       lineArmed_r;
   logic [1:0] seqIdx_r;

   function automatic logic [1:0] orderEntry(input logic [5:0] ord,
                                             input logic [1:0] idx);
      orderEntry = ord[2*idx +: 2];
   endfunction : orderEntry

   // a mode change disarms, so the next pulse restarts at entry zero
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         modePrev_r   <= MODE_TRIPLE;
         lineArmed_r  <= 1'b0;
         seqIdx_r     <= '0;
         activeChan_r <= CH_RED;
         coefSet_r    <= SET_ZERO;
      end else begin
         modePrev_r <= mode;
         if (mode != modePrev_r) begin
            lineArmed_r <= 1'b0;
            seqIdx_r    <= '0;
            coefSet_r   <= SET_ZERO;
         end else if (lineTransferPulse) begin
            lineArmed_r <= 1'b1;
            case (mode)
               MODE_LINE_SEQ: begin
                  if (!lineArmed_r) begin
                     seqIdx_r     <= 2'h1;
                     activeChan_r <= orderEntry(chanOrder, 2'h0); // [R8]
                  end else begin
                     activeChan_r <= orderEntry(chanOrder, seqIdx_r); // [R9]
                     seqIdx_r <= (seqIdx_r == 2'h2) ? 2'h0
                                                    : seqIdx_r + 1'b1; // [R10]
                  end
               end
               MODE_SINGLE_MULTI: begin
                  activeChan_r <= singleSel;             // [R6]
                  if (!lineArmed_r || singleSel != CH_RED) begin
                     coefSet_r <= SET_ZERO;
                  end else if (coefSet_r + 1'b1 >= numColorSets ||
                               coefSet_r == 3'(NUM_SETS_MAX-1)) begin
                     coefSet_r <= SET_ZERO;              // [R7]
                  end else begin
                     coefSet_r <= coefSet_r + 1'b1;      // [R7]
                  end
               end
               default: begin
                  coefSet_r <= SET_ZERO;
               end
            endcase
         end
      end
   end

   //---------------------------------------------------------------------
   // steering: one pixel in, one to three converter words out
   //---------------------------------------------------------------------
   typedef enum logic {ST_IDLE, ST_EMIT} afis_state_t;

   afis_state_t state_r;
   afis_pixel_t hold_r;
   logic [1:0]  slot_r;
   logic [1:0]  lastSlot_r;
   logic [1:0]  slotChan;
   logic        fifoReady;
   logic        fifoValid;
   afis_conv_t  fifoWord;
   logic        pixTake;
   logic        seqBlocked;

   // line-sequential mode samples nothing until its first line pulse
   assign seqBlocked = (mode == MODE_LINE_SEQ) && !lineArmed_r; // [R8]
   assign pixReady   = (state_r == ST_IDLE) && !seqBlocked;
   assign pixTake    = pixValid & pixReady;

   // channel presented in the current converter slot
   always_comb begin
      case (mode)
         MODE_TRIPLE: slotChan = orderEntry(chanOrder, slot_r);   // [R4]
         MODE_DUAL:   slotChan = slot_r[0] ? CH_GREEN : CH_BLUE;  // [R5]
         default:     slotChan = activeChan_r;                    // [R6]
      endcase
   end

   always_comb begin
      fifoWord.chan    = slotChan;
      fifoWord.coefSet = coefSet_r;
      case (slotChan)
         CH_GREEN: fifoWord.data = hold_r.green;
         CH_BLUE:  fifoWord.data = hold_r.blue;
         default:  fifoWord.data = hold_r.red;
      endcase
   end

   assign fifoValid = (state_r == ST_EMIT);

   // a full fifo stalls emission, which in turn drops pixReady
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_r    <= ST_IDLE;
         hold_r     <= '0;
         slot_r     <= '0;
         lastSlot_r <= '0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (pixTake) begin
                  hold_r  <= pixData;                    // [R4]
                  slot_r  <= '0;
                  state_r <= ST_EMIT;
                  case (mode)
                     MODE_TRIPLE: lastSlot_r <= 2'h2;    // [R4]
                     MODE_DUAL:   lastSlot_r <= 2'h1;    // [R18]
                     default:     lastSlot_r <= 2'h0;
                  endcase
               end
            end
            ST_EMIT: begin
               if (fifoReady) begin
                  if (slot_r == lastSlot_r) begin
                     state_r <= ST_IDLE;
                  end else begin
                     slot_r <= slot_r + 1'b1;            // [R18]
                  end
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   afis_fifo #(
      .WIDTH (CONV_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .inValid  (fifoValid),
      .inReady  (fifoReady),
      .inData   (fifoWord),
      .outValid (convValid),
      .outReady (convReady),
      .outData  (convWord)
   );

   //---------------------------------------------------------------------
   // input clamp pulse
   //---------------------------------------------------------------------
   logic [PIXCNT_W-1:0] pixCnt_r;
   logic [PIXCNT_W:0]   clampEnd;

   assign clampEnd = {1'b0, clampDelay} + {1'b0, clampWidth};

   // pixels counted from the line pulse; the pulse itself is pixel zero
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pixCnt_r     <= '0;
         inputClamp_r <= 1'b0;
      end else begin
         if (lineTransferPulse) begin
            pixCnt_r <= '0;
         end else if (pixTake && pixCnt_r != '1) begin
            pixCnt_r <= pixCnt_r + 1'b1;
         end
         inputClamp_r <= !lineTransferPulse && clampWidth != '0 &&
                         pixCnt_r >= clampDelay &&
                         {1'b0, pixCnt_r} < clampEnd;    // [R11]
      end
   end

   // gating drops the reset-noise part of each pixel from the clamp
   assign clampSwitch = clampGateEn ? (inputClamp_r & sampleStrobe)  // [R13]
                                    : inputClamp_r;                  // [R12]

   //---------------------------------------------------------------------
   // black level loops, one per channel
   //---------------------------------------------------------------------
   // a one-step integrator: slow, but it cannot overshoot on noisy black
   for (genvar ch = 0; ch < 3; ch++) begin : g_blc
      logic [SAMPLE_W-1:0] black;
      logic [OFFSET_W-1:0] offs;

      assign offs  = offset_r[ch*OFFSET_W +: OFFSET_W];
      assign black = (ch == 0) ? pixData.red :
                     (ch == 1) ? pixData.green : pixData.blue;

      always_ff @(posedge clk) begin
         if (sys_rst) begin
            offset_r[ch*OFFSET_W +: OFFSET_W] <= OFFSET_RST;
         end else if (!blcAuto[ch]) begin
            offset_r[ch*OFFSET_W +: OFFSET_W] <=
               manualOffset[ch*OFFSET_W +: OFFSET_W];    // [R14]
         end else if (pixTake && inputClamp_r) begin
            if (black > BLACK_TGT && offs != '0) begin
               offset_r[ch*OFFSET_W +: OFFSET_W] <= offs - 1'b1; // [R15]
            end else if (black < BLACK_TGT && offs != '1) begin
               offset_r[ch*OFFSET_W +: OFFSET_W] <= offs + 1'b1; // [R15]
            end
         end
      end
   end

endmodule : afis_input_sequencer

//--- sim/afis_properties.sv
// checker: timing relations seen at the input sequencer's ports
`timescale 1ns/100ps
module afis_checker
   import afis_pkg::*;
(
   // clock and reset
   input wire logic                  clk,
   input wire logic                  sys_rst,
   // configuration and timing inputs
   input wire logic                  clkNegLevel,
   input wire logic [7:0]            mainConfig1,
   input wire afis_mode_t            mode,
   input wire logic [5:0]            chanOrder,
   input wire logic [1:0]            singleSel,
   input wire logic [2:0]            numColorSets,
   input wire logic                  clampGateEn,
   input wire logic [2:0]            blcAuto,
   input wire logic [3*OFFSET_W-1:0] manualOffset,
   input wire logic                  lineTransferPulse,
   input wire logic                  sampleStrobe,
   // outputs watched
   input wire logic                  pixReady,
   input wire logic                  clkDiff_r,
   input wire logic [1:0]            mult_r,
   input wire logic                  inputClamp_r,
   input wire logic                  clampSwitch,
   input wire logic [3*OFFSET_W-1:0] offset_r,
   input wire logic [1:0]            activeChan_r,
   input wire logic [2:0]            coefSet_r
);
   //----------------
   // helper logic
   //----------------
   logic [7:0] quietCnt_r;
   logic [1:0] nxtChan;
   logic [2:0] nxtSet;

   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   // edges since the negative clock pin last moved, saturating
   always_ff @(posedge clk) begin
      if (sys_rst || $changed(clkNegLevel))
         quietCnt_r <= 8'h00;
      else if (quietCnt_r != 8'hFF)
         quietCnt_r <= quietCnt_r + 8'h01;
   end

   // next entry of the programmed order, wrapping after the third
   always_comb begin
      if (activeChan_r == chanOrder[1:0])
         nxtChan = chanOrder[3:2];
      else if (activeChan_r == chanOrder[3:2])
         nxtChan = chanOrder[5:4];
      else
         nxtChan = chanOrder[1:0];
   end
   assign nxtSet = (coefSet_r + 3'h1 >= numColorSets) ? 3'h0
                 : coefSet_r + 3'h1;

   //----------------
   // properties
   //----------------
   property p_multPix;
      (mainConfig1[CLKSEL_BIT] && mode inside {MODE_TRIPLE, MODE_DUAL}
         && $stable(mode))[*3]
         |-> mult_r == ((mode == MODE_TRIPLE) ? MULT_THREE : MULT_TWO);
   endproperty
   a_multPix: assert property (p_multPix)
      else $error("pixel clock multiplier wrong");
   property p_multOne;
      ((!mainConfig1[CLKSEL_BIT] || mode inside {MODE_SINGLE_MULTI,
         MODE_LINE_SEQ}) && $stable(mode) && $stable(mainConfig1))[*3]
         |-> mult_r == MULT_ONE;
   endproperty
   a_multOne: assert property (p_multOne)
      else $error("multiplier not one");
   property p_clampGate;
      clampSwitch == (inputClamp_r && (sampleStrobe || !clampGateEn));
   endproperty
   a_clampGate: assert property (p_clampGate)
      else $error("clamp switch wrong");
   property p_seqStep;
      lineTransferPulse && pixReady && mode == MODE_LINE_SEQ
         && $stable(mode) && $past(mode, 2) == mode
         |=> activeChan_r == $past(nxtChan);
   endproperty
   a_seqStep: assert property (p_seqStep)
      else $error("no line step");
   property p_singleSel;
      lineTransferPulse && mode == MODE_SINGLE_MULTI && $stable(mode)
         && $past(mode, 2) == mode |=> activeChan_r == $past(singleSel);
   endproperty
   a_singleSel: assert property (p_singleSel)
      else $error("wrong single input");
   property p_coefStep;
      lineTransferPulse && mode == MODE_SINGLE_MULTI && $stable(mode)
         && singleSel == CH_RED && coefSet_r != 3'h0
         && numColorSets inside {[3'h2:3'h5]}
         |=> coefSet_r == $past(nxtSet);
   endproperty
   a_coefStep: assert property (p_coefStep)
      else $error("no coef step");
   property p_manualOff;
      (blcAuto == 3'h0)[*2] |-> offset_r == $past(manualOffset);
   endproperty
   a_manualOff: assert property (p_manualOff)
      else $error("manual offset lost");
   property p_clkDiff;
      $changed(clkNegLevel) |=> clkDiff_r;
   endproperty
   a_clkDiff: assert property (p_clkDiff)
      else $error("no diff clock");
   property p_clkQuiet;
      quietCnt_r >= 8'h16 |-> !clkDiff_r;
   endproperty
   a_clkQuiet: assert property (p_clkQuiet)
      else $error("no single clock");
endmodule : afis_checker

//--- sim/afis_sensor_model.sv
// sensor model: pixel stream, line-transfer pulses and sample strobe
`timescale 1ns/100ps
module afis_sensor_model
   import afis_pkg::*;
(
   // clock
   input  wire logic  clk,
   // sensor timing
   output logic       lineTransferPulse,
   output logic       sampleStrobe,
   // pixel stream
   output logic       pixValid,
   input  wire logic  pixReady,
   output afis_pixel_t pixData
);
   initial {lineTransferPulse, sampleStrobe, pixValid, pixData} = '0;

   // strobe marks the signal half of every pixel period
   always @(posedge clk) sampleStrobe <= #1 ~sampleStrobe;

   // one-cycle line-transfer pulse at the start of a line
   task pulse;
      @(posedge clk);
      #1 lineTransferPulse = 1'b1;
      @(posedge clk);
      #1 lineTransferPulse = 1'b0;
   endtask : pulse

   // colours offered together; inverted once released
   task sendPix(input afis_pixel_t p, output logic ok);
      logic rdy;
      @(posedge clk);
      #1 pixValid = 1'b1;
      pixData = p;
      ok = 1'b0;
      for (int n = 0; n < 20 && !ok; n++) begin
         @(negedge clk) rdy = pixReady;
         @(posedge clk) ok = rdy;
      end
      #1 pixValid = 1'b0;
      pixData = ~p;
   endtask : sendPix
endmodule : afis_sensor_model

//--- sim/testbench.sv
// testbench: drives the input sequencer through its modes
`timescale 1ns/100ps
module testbench;
   import afis_pkg::*;
   logic clk, sys_rst, clkPosLevel, clkNegLevel, clampGateEn, convReady;
   logic lineTransferPulse, sampleStrobe, pixValid, pixReady, convValid;
   logic clkDiff_r, inputClamp_r, clampSwitch, ok, tk;
   logic [7:0] mainConfig1;
   logic [5:0] chanOrder;
   logic [1:0] singleSel, mult_r, activeChan_r;
   logic [2:0] numColorSets, blcAuto, cdsSel, inBufEn_r, cdsMode_r;
   logic [2:0] coefSet_r;
   logic [PIXCNT_W-1:0] clampDelay, clampWidth;
   logic [3*OFFSET_W-1:0] manualOffset, offset_r;
   afis_mode_t mode;
   afis_pixel_t pixData;
   afis_conv_t convWord, wd;
   logic [17:0] got[$], expQ[$];
   int err_count = 0, checks_done = 0, acc;
   // mode, clock select, expected multiplier
   localparam logic [4:0] ROWS [8] = '{5'h07, 5'h01, 5'h0E, 5'h09,
                                        5'h15, 5'h11, 5'h1D, 5'h19};

   afis_input_sequencer uut (.*);
   afis_sensor_model snr (.*);

   //----------------
   // clock, watchdog and converter-side collector
   //----------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #100000;
      err_count++;
      test_done();
   end
   // sampled mid-cycle, clear of the fifo's edge updates
   always @(negedge clk) begin
      tk = convValid & convReady;
      wd = convWord;
   end
   always @(posedge clk) if (tk) got.push_back({wd.chan, wd.data});

   //----------------
   // helpers
   //----------------
   task check(input string name, input logic [31:0] seen, want);
      checks_done++;
      if (seen !== want) begin
         err_count++;
         $display("Error %s expected %h seen %h", name, want, seen);
      end
   endtask : check
   task test_done;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done
   function afis_pixel_t px(input int i);
      return {16'h1000 + 16'(i), 16'h2000 + 16'(i), 16'h3000 + 16'(i)};
   endfunction : px
   // expected converter word for one colour of a pixel
   task want(input afis_pixel_t p, input logic [1:0] c);
      expQ.push_back({c, (c == CH_RED) ? p.red :
                         (c == CH_GREEN) ? p.green : p.blue});
   endtask : want
   task waitCyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : waitCyc
   // release the sink and compare all that arrives
   task drain;
      convReady = 1'b1;
      for (int n = 0; n < 200 && got.size() < expQ.size(); n++)
         @(posedge clk);
      waitCyc(4);
      check("count", got.size(), expQ.size());
      check("empty", convValid, 1'b0);
      while (expQ.size() > 0 && got.size() > 0)
         check("word", got.pop_front(), expQ.pop_front());
      got.delete();
      expQ.delete();
      convReady = 1'b0;
   endtask : drain

   //----------------
   // main sequence
   //----------------
   initial begin
      {sys_rst, clkPosLevel, clkNegLevel, convReady} = 4'h8;
      {mainConfig1, cdsSel, blcAuto} = '0;
      mode = MODE_SINGLE_MULTI;
      chanOrder = 6'h12; // blue, then red, then green
      {singleSel, numColorSets} = {CH_GREEN, 3'h3};
      {clampDelay, clampWidth, clampGateEn} = {12'h002, 12'h003, 1'b1};
      manualOffset = {10'h155, 10'h0AA, 10'h200};
      waitCyc(16);
      sys_rst = 1'b0;
      check("rst mult", mult_r, MULT_ONE);
      check("rst offset", offset_r, {3{OFFSET_RST}});
      check("rst valid", convValid, 1'b0);
      // clock format: toggling minus pin, then grounded
      for (int i = 0; i < 6; i++) begin
         waitCyc(1);
         clkNegLevel = ~clkNegLevel;
      end
      waitCyc(1);
      check("diff", clkDiff_r, 1'b1);
      waitCyc(30);
      check("single", clkDiff_r, 1'b0);
      // table of mode and clock-select settings
      for (int i = 0; i < 8; i++) begin
         mode = afis_mode_t'(ROWS[i][4:3]);
         mainConfig1 = {ROWS[i][2], 4'h0, ROWS[i][2], 2'h0};
         cdsSel = 3'(i);
         waitCyc(4);
         check("mult", mult_r, ROWS[i][1:0]);
         check("inbuf", inBufEn_r, {3{ROWS[i][2]}});
         check("cds", cdsMode_r, cdsSel);
      end
      // triple then dual: two pixels each into a stalled sink
      for (int m = 0; m < 2; m++) begin
         mode = (m == 0) ? MODE_TRIPLE : MODE_DUAL;
         mainConfig1 = 8'h04;
         waitCyc(3);
         snr.pulse();
         for (int i = 0; i < 2; i++) begin
            snr.sendPix(px(i), ok);
            for (int k = 0; k < 3 - m; k++)
               want(px(i), (m == 1) ? ((k == 0) ? CH_BLUE : CH_GREEN)
                                    : chanOrder[2*k +: 2]);
         end
         drain();
      end
      // single input: fill until refused, then drain
      mode = MODE_SINGLE_MULTI;
      waitCyc(3);
      snr.pulse();
      acc = 0;
      ok = 1'b1;
      while (ok && acc < 12) begin
         snr.sendPix(px(acc + 4), ok);
         if (ok) begin
            want(px(acc + 4), CH_GREEN);
            acc++;
         end
      end
      check("fill", acc, FIFO_DEPTH + 1);
      drain();
      // line-sequential: idle until first pulse, then cycle the order
      mode = MODE_LINE_SEQ;
      waitCyc(3);
      check("seq idle", pixReady, 1'b0);
      for (int k = 0; k < 4; k++) begin
         snr.pulse();
         check("seq", activeChan_r, chanOrder[2*(k%3)+:2]);
         if (k == 0) begin
            snr.sendPix(px(9), ok);
            want(px(9), CH_BLUE);
            drain();
         end
      end
      // single red: coefficient sets step per line
      mode = MODE_SINGLE_MULTI;
      singleSel = CH_RED;
      waitCyc(3);
      for (int k = 0; k < 4; k++) begin
         snr.pulse();
         check("coef", coefSet_r, 3'(k % 3));
      end
      // clamp window after the pulse, automatic black level on red
      convReady = 1'b1;
      blcAuto = 3'h1;
      snr.pulse();
      check("clamp0", inputClamp_r, 1'b0);
      for (int k = 1; k < 8; k++) begin
         clampGateEn = k[0];
         snr.sendPix({16'h0200, 16'h2000, 16'h3000}, ok);
         waitCyc(2);
         check("clamp", inputClamp_r, k >= 2 && k < 5);
      end
      check("auto offset", offset_r[9:0], 10'h1FD);
      check("manual offset", offset_r[29:10], manualOffset[29:10]);
      test_done();
   end
endmodule : testbench

bind afis_input_sequencer afis_checker chk (.*);
